/* pkg/clu_defs.svh */
// constants of the character display instruction unit
//
// How it works
// - clear fills spaces, zeroes counter, sets increment
// - return home zeroes counter, undoes shift
// - entry mode latches step direction
// - glyph accesses step like text accesses
// - text write with auto-scroll shifts display
// - display off blanks, memory kept
// - cursor off hides cursor, direction kept
// - blink alternates cursor cell with all-on
// - shift instruction moves cursor or display
// - display shift keeps counter, no memory access
// - two-line cursor wraps from line one to two
// - display shift rotates each line together
// - function set latches width, lines, font
// - glyph address loads six bits, selects glyphs
// - text address loads seven bits, selects text
// - status read gives busy and counter
// - every data access steps the counter
// - data write stores byte, busy 43 us
// - data read drives byte, busy 43 us
// - bus width bit selects eight or four
// - two-line text map 00-27 and 40-67
// - line bit and font bit meanings
`ifndef CLU_DEFS_SVH
`define CLU_DEFS_SVH

// -----------------------------------------------------------------
// timing
// -----------------------------------------------------------------
`define CLU_CLK_NS 10
`define CLU_T_HOME_NS 1530000
`define CLU_T_INSTR_NS 39000
`define CLU_T_DATA_NS 43000
`define CLU_T_BLINK_NS 400000000

// -----------------------------------------------------------------
// instruction bit positions
// -----------------------------------------------------------------
`define CLU_BIT_CLEAR 0
`define CLU_BIT_HOME 1
`define CLU_BIT_ENTRY 2
`define CLU_BIT_ONOFF 3
`define CLU_BIT_SHIFT 4
`define CLU_BIT_FUNC 5
`define CLU_BIT_GLYPH 6
`define CLU_BIT_TEXT 7

// -----------------------------------------------------------------
// address map and codes
// -----------------------------------------------------------------
`define CLU_LINE1_END 7'h27
`define CLU_LINE2_START 7'h40
`define CLU_LINE2_END 7'h67
`define CLU_ONELINE_END 7'h4f
`define CLU_LINE_LEN_TWO 7'h28
`define CLU_LINE_LEN_ONE 7'h50
`define CLU_SPACE 8'h20
`define CLU_ALL_ON 8'hff
`define CLU_TEXT_DEPTH 128
`define CLU_GLYPH_DEPTH 64
`define CLU_FIFO_DEPTH 16
`define CLU_FIFO_WIDTH 10

// -----------------------------------------------------------------
// reset values
// -----------------------------------------------------------------
`define CLU_RST_BUS8 1'b1
`define CLU_RST_INC 1'b1
`define CLU_RST_TWO 1'b0

`endif

/* pkg/clu_pkg.sv */
// types of the character display instruction unit
package clu_pkg;
  typedef enum logic [1:0] {
    CLU_IDLE,
    CLU_FILL,
    CLU_WAIT
  } clu_state_e;
  typedef logic [6:0] clu_addr_t;
endpackage

/* src/clu_char_lcd.sv */
// instruction unit of a two-line character display, with its command queue
`timescale 1ns/1ns
`include "clu_defs.svh"

// -----------------------------------------------------------------
// command queue
// -----------------------------------------------------------------
module clu_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 16
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] store_reg [DEPTH];
  logic [AW-1:0] wrPtr_reg;
  logic [AW-1:0] rdPtr_reg;
  logic [AW:0] count_reg;
  wire doPush = inValid && inReady;
  wire doPop = outValid && outReady;

  assign inReady = count_reg != (AW+1)'(DEPTH);
  assign outValid = count_reg != '0;
  assign outData = store_reg[rdPtr_reg];

  always_ff @(posedge clock) begin
    if (doPush) begin
      store_reg[wrPtr_reg] <= inData;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      wrPtr_reg <= '0;
      rdPtr_reg <= '0;
      count_reg <= '0;
    end else begin
      wrPtr_reg <= doPush ? wrPtr_reg + 1'b1 : wrPtr_reg;
      rdPtr_reg <= doPop ? rdPtr_reg + 1'b1 : rdPtr_reg;
      count_reg <= count_reg + (AW+1)'(doPush) - (AW+1)'(doPop);
    end
  end
endmodule // clu_fifo

// -----------------------------------------------------------------
// instruction unit
// -----------------------------------------------------------------
module clu_char_lcd #(
  parameter int HOME_CYCLES = `CLU_T_HOME_NS / `CLU_CLK_NS,
  parameter int DATA_CYCLES = `CLU_T_DATA_NS / `CLU_CLK_NS,
  parameter int BLINK_CYCLES = `CLU_T_BLINK_NS / `CLU_CLK_NS
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic regSelect,
  input wire logic readNotWrite,
  input wire logic strobe,
  input wire logic [7:0] dataIn,
  output logic [7:0] dataOut,
  output logic dataOe,
  input wire logic [6:0] scanAddr,
  output logic [7:0] scanChar,
  output logic displayEnable,
  output logic cursorShow,
  output logic blinkEnable,
  output logic twoLineMode,
  output logic tallFont,
  output logic busWidth8,
  output logic [6:0] displayOffset,
  output logic [6:0] addressCounter,
  output logic busyIndicator,
  output logic queueReady
);
  localparam int INSTR_CYCLES = `CLU_T_INSTR_NS / `CLU_CLK_NS;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // auto step of the counter, text wraps per line layout
  function automatic clu_pkg::clu_addr_t stepAddr(input clu_pkg::clu_addr_t a,
      input logic inc, input logic two, input logic glyph);
    clu_pkg::clu_addr_t r;
    r = inc ? a + 7'h01 : a - 7'h01;
    if (glyph) begin
      r = {1'b0, r[5:0]};
    end else if (two) begin
      if (inc && a == `CLU_LINE1_END) r = `CLU_LINE2_START;
      else if (inc && a == `CLU_LINE2_END) r = 7'h00;
      else if (!inc && a == 7'h00) r = `CLU_LINE2_END;
      else if (!inc && a == `CLU_LINE2_START) r = `CLU_LINE1_END;
    end else begin
      if (inc && a == `CLU_ONELINE_END) r = 7'h00;
      else if (!inc && a == 7'h00) r = `CLU_ONELINE_END;
    end
    return r;
  endfunction

  // one offset rotates every line inside its own range
  function automatic clu_pkg::clu_addr_t shiftOff(input clu_pkg::clu_addr_t o,
      input logic left, input logic two);
    clu_pkg::clu_addr_t len;
    len = two ? `CLU_LINE_LEN_TWO : `CLU_LINE_LEN_ONE;
    if (left) return (o >= len - 7'h01) ? 7'h00 : o + 7'h01;
    return (o == 7'h00 || o >= len) ? len - 7'h01 : o - 7'h01;
  endfunction

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic [10:0] pinMeta_reg;
  logic [10:0] pinSync_reg;
  logic strobeLast_reg;
  always_ff @(posedge clock) begin
    pinMeta_reg <= {regSelect, readNotWrite, strobe, dataIn};
    pinSync_reg <= pinMeta_reg;
    strobeLast_reg <= srst ? 1'b0 : pinSync_reg[8];
  end
  wire sRs = pinSync_reg[10];
  wire sRw = pinSync_reg[9];
  wire sStrobe = pinSync_reg[8];
  wire [7:0] sData = pinSync_reg[7:0];
  wire strobeRise = sStrobe && !strobeLast_reg;
  wire strobeFall = !sStrobe && strobeLast_reg;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [7:0] textMem_reg [`CLU_TEXT_DEPTH];
  logic [7:0] glyphMem_reg [`CLU_GLYPH_DEPTH];
  clu_pkg::clu_state_e state_reg, state_next;
  logic [31:0] busyCnt_reg, busyCnt_next;
  clu_pkg::clu_addr_t fillIdx_reg;
  clu_pkg::clu_addr_t ac_reg, ac_next;
  clu_pkg::clu_addr_t off_reg, off_next;
  logic inc_reg, inc_next;
  logic scroll_reg, scroll_next;
  logic disp_reg, disp_next;
  logic cur_reg, cur_next;
  logic blink_reg, blink_next;
  logic bus8_reg, bus8_next;
  logic two_reg, two_next;
  logic tall_reg, tall_next;
  logic glyphSel_reg, glyphSel_next;
  logic nibblePhase_reg;
  logic [3:0] upperNib_reg;
  logic [7:0] readByte_reg;
  logic [31:0] blinkCnt_reg;
  logic blinkPhase_reg;

  // ---------------------------------------------------------------
  // host side: status and data reads, write capture
  // ---------------------------------------------------------------
  wire [7:0] memByte = glyphSel_reg ? glyphMem_reg[ac_reg[5:0]] : textMem_reg[ac_reg];
  wire [7:0] statusByte = {busyIndicator, ac_reg};
  wire firstNibble = !bus8_reg && !nibblePhase_reg;
  wire [7:0] readSrc = sRs ? memByte : statusByte;
  wire [7:0] readView = firstNibble ? {readSrc[7:4], 4'h0} :
                        bus8_reg ? readSrc : {readByte_reg[3:0], 4'h0};
  wire byteDone = bus8_reg || nibblePhase_reg;
  wire [7:0] writeByte = bus8_reg ? sData : {upperNib_reg, sData[7:4]};
  // a data read queues only its counter step
  wire fifoInValid = strobeFall && byteDone && (!sRw || sRs);
  wire [9:0] fifoInData = {sRw, sRs, writeByte};
  wire fifoInReady;
  wire fifoOutValid;
  wire [9:0] fifoOutData;
  wire fifoPop = fifoOutValid && state_reg == clu_pkg::CLU_IDLE;

  clu_fifo #(
    .WIDTH(`CLU_FIFO_WIDTH),
    .DEPTH(`CLU_FIFO_DEPTH)
  ) cmdQueue (
    .clock(clock),
    .srst(srst),
    .inValid(fifoInValid),
    .inReady(fifoInReady),
    .inData(fifoInData),
    .outValid(fifoOutValid),
    .outReady(fifoPop),
    .outData(fifoOutData)
  );

  always_ff @(posedge clock) begin
    if (srst) begin
      dataOut <= 8'h00;
      dataOe <= 1'b0;
      readByte_reg <= 8'h00;
    end else if (strobeRise && sRw) begin
      dataOut <= readView;
      dataOe <= 1'b1;
      readByte_reg <= firstNibble ? readSrc : readByte_reg;
    end else if (strobeFall) begin
      dataOe <= 1'b0;
    end
  end

  // four-bit mode pairs two strobes into one byte
  always_ff @(posedge clock) begin
    if (srst) begin
      nibblePhase_reg <= 1'b0;
      upperNib_reg <= 4'h0;
    end else if (strobeFall && !bus8_reg) begin
      nibblePhase_reg <= !nibblePhase_reg;
      upperNib_reg <= nibblePhase_reg ? upperNib_reg : sData[7:4];
    end
  end

  // ---------------------------------------------------------------
  // executor
  // ---------------------------------------------------------------
  wire cmdRw = fifoOutData[9];
  wire cmdRs = fifoOutData[8];
  wire [7:0] cmd = fifoOutData[7:0];
  logic textWe;
  logic glyphWe;
  clu_pkg::clu_addr_t textWa;
  logic [7:0] textWd;

  always_comb begin
    state_next = state_reg;
    busyCnt_next = busyCnt_reg == 32'd0 ? 32'd0 : busyCnt_reg - 32'd1;
    ac_next = ac_reg;
    off_next = off_reg;
    inc_next = inc_reg;
    scroll_next = scroll_reg;
    disp_next = disp_reg;
    cur_next = cur_reg;
    blink_next = blink_reg;
    bus8_next = bus8_reg;
    two_next = two_reg;
    tall_next = tall_reg;
    glyphSel_next = glyphSel_reg;
    textWe = 1'b0;
    glyphWe = 1'b0;
    textWa = ac_reg;
    textWd = cmd;
    if (state_reg == clu_pkg::CLU_FILL) begin
      textWe = 1'b1;
      textWa = fillIdx_reg;
      textWd = `CLU_SPACE;
      if (fillIdx_reg == 7'h7f) state_next = clu_pkg::CLU_WAIT;
    end else if (state_reg == clu_pkg::CLU_WAIT) begin
      if (busyCnt_reg <= 32'd1) state_next = clu_pkg::CLU_IDLE;
    end else if (fifoPop) begin
      state_next = clu_pkg::CLU_WAIT;
      busyCnt_next = 32'(INSTR_CYCLES);
      if (cmdRs) begin
        busyCnt_next = 32'(DATA_CYCLES);
        ac_next = stepAddr(ac_reg, inc_reg, two_reg, glyphSel_reg);
        if (!cmdRw) begin
          textWe = !glyphSel_reg;
          glyphWe = glyphSel_reg;
          if (scroll_reg && !glyphSel_reg) off_next = shiftOff(off_reg, inc_reg, two_reg);
        end
      end else if (cmd[`CLU_BIT_TEXT]) begin
        ac_next = cmd[6:0];
        glyphSel_next = 1'b0;
      end else if (cmd[`CLU_BIT_GLYPH]) begin
        ac_next = {1'b0, cmd[5:0]};
        glyphSel_next = 1'b1;
      end else if (cmd[`CLU_BIT_FUNC]) begin
        bus8_next = cmd[4];
        two_next = cmd[3];
        tall_next = cmd[2];
      end else if (cmd[`CLU_BIT_SHIFT]) begin
        // display shift leaves the counter and memories alone
        if (cmd[3]) off_next = shiftOff(off_reg, !cmd[2], two_reg);
        else ac_next = stepAddr(ac_reg, cmd[2], two_reg, glyphSel_reg);
      end else if (cmd[`CLU_BIT_ONOFF]) begin
        disp_next = cmd[2];
        cur_next = cmd[1];
        blink_next = cmd[0];
      end else if (cmd[`CLU_BIT_ENTRY]) begin
        inc_next = cmd[1];
        scroll_next = cmd[0];
      end else if (cmd[`CLU_BIT_HOME]) begin
        busyCnt_next = 32'(HOME_CYCLES);
        ac_next = 7'h00;
        off_next = 7'h00;
        glyphSel_next = 1'b0;
      end else if (cmd[`CLU_BIT_CLEAR]) begin
        state_next = clu_pkg::CLU_FILL;
        busyCnt_next = 32'(HOME_CYCLES);
        ac_next = 7'h00;
        off_next = 7'h00;
        inc_next = 1'b1;
        glyphSel_next = 1'b0;
      end else begin
        state_next = clu_pkg::CLU_IDLE;
        busyCnt_next = 32'd0;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (textWe) textMem_reg[textWa] <= textWd;
    if (glyphWe) glyphMem_reg[ac_reg[5:0]] <= cmd;
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      state_reg <= clu_pkg::CLU_IDLE;
      busyCnt_reg <= 32'd0;
      fillIdx_reg <= 7'h00;
      {ac_reg, off_reg, glyphSel_reg} <= {7'h00, 7'h00, 1'b0};
      {inc_reg, scroll_reg} <= {`CLU_RST_INC, 1'b0};
      {disp_reg, cur_reg, blink_reg} <= 3'b000;
      {bus8_reg, two_reg, tall_reg} <= {`CLU_RST_BUS8, `CLU_RST_TWO, 1'b0};
    end else begin
      state_reg <= state_next;
      busyCnt_reg <= busyCnt_next;
      fillIdx_reg <= state_reg == clu_pkg::CLU_FILL ? fillIdx_reg + 7'h01 : 7'h00;
      {ac_reg, off_reg, glyphSel_reg} <= {ac_next, off_next, glyphSel_next};
      {inc_reg, scroll_reg} <= {inc_next, scroll_next};
      {disp_reg, cur_reg, blink_reg} <= {disp_next, cur_next, blink_next};
      {bus8_reg, two_reg, tall_reg} <= {bus8_next, two_next, tall_next};
    end
  end

  // ---------------------------------------------------------------
  // display view
  // ---------------------------------------------------------------
  wire cursorCell = scanAddr == ac_reg && !glyphSel_reg;
  wire [7:0] scanNext = !disp_reg ? `CLU_SPACE :
                        (blink_reg && blinkPhase_reg && cursorCell) ? `CLU_ALL_ON :
                        textMem_reg[scanAddr];

  always_ff @(posedge clock) begin
    if (srst || !blink_reg) begin
      blinkCnt_reg <= 32'd0;
      blinkPhase_reg <= 1'b0;
    end else if (blinkCnt_reg >= 32'(BLINK_CYCLES - 1)) begin
      blinkCnt_reg <= 32'd0;
      blinkPhase_reg <= !blinkPhase_reg;
    end else begin
      blinkCnt_reg <= blinkCnt_reg + 32'd1;
    end
  end

  // queued work counts as busy so a poll never races the queue
  always_ff @(posedge clock) begin
    if (srst) begin
      scanChar <= `CLU_SPACE;
      busyIndicator <= 1'b0;
      queueReady <= 1'b1;
      {displayEnable, cursorShow, blinkEnable} <= 3'b000;
      {twoLineMode, tallFont, busWidth8} <= {`CLU_RST_TWO, 1'b0, `CLU_RST_BUS8};
      displayOffset <= 7'h00;
      addressCounter <= 7'h00;
    end else begin
      scanChar <= scanNext;
      busyIndicator <= state_next != clu_pkg::CLU_IDLE || fifoOutValid;
      queueReady <= fifoInReady;
      {displayEnable, cursorShow, blinkEnable} <= {disp_reg, cur_reg && disp_reg, blink_reg};
      {twoLineMode, tallFont, busWidth8} <= {two_reg, tall_reg, bus8_reg};
      displayOffset <= off_reg;
      addressCounter <= ac_reg;
    end
  end
endmodule // clu_char_lcd

/* verif/clu_char_lcd_assertions.sv */
// checker of the character display instruction unit ports
`timescale 1ns/1ns
module clu_checker #(
  parameter int HOME_CYCLES = 153000,
  parameter int DATA_CYCLES = 4300,
  parameter int BLINK_CYCLES = 40000000
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic readNotWrite,
  input wire logic strobe,
  input wire logic [7:0] scanChar,
  input wire logic dataOe,
  input wire logic displayEnable,
  input wire logic cursorShow,
  input wire logic twoLineMode,
  input wire logic tallFont,
  input wire logic busWidth8,
  input wire logic [6:0] displayOffset,
  input wire logic [6:0] addressCounter,
  input wire logic busyIndicator,
  input wire logic queueReady
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);
  // -----------------------------------------------------------------
  // pin bus
  // -----------------------------------------------------------------
  sequence s_drive;
    dataOe [*2];
  endsequence
  sequence s_quiet;
    !dataOe [*4];
  endsequence
  property p_oe_cause;
    $rose(dataOe) |-> $past(strobe, 2) && $past(readNotWrite, 2);
  endproperty
  a_oe_cause: assert property (p_oe_cause) else $error("bus driven without read");
  property p_oe_hold;
    $rose(dataOe) |-> s_drive;
  endproperty
  a_oe_hold: assert property (p_oe_hold) else $error("read data glitched");
  property p_oe_release;
    $fell(strobe) |-> ##[1:6] !dataOe;
  endproperty
  a_oe_release: assert property (p_oe_release) else $error("bus not released");
  property p_write_quiet;
    $rose(strobe) && !readNotWrite |-> ##2 s_quiet;
  endproperty
  a_write_quiet: assert property (p_write_quiet) else $error("bus driven on write");
  // -----------------------------------------------------------------
  // display view checks, and executor effects only happen while busy
  // -----------------------------------------------------------------
  property p_blank;
    !displayEnable && $past(displayEnable) == 1'b0 |-> scanChar == 8'h20;
  endproperty
  a_blank: assert property (p_blank) else $error("screen not blanked");
  property p_cursor;
    cursorShow |-> displayEnable;
  endproperty
  a_cursor: assert property (p_cursor) else $error("cursor shown while off");
  property p_func_busy;
    $changed(busWidth8) || $changed(twoLineMode) || $changed(tallFont) |-> busyIndicator;
  endproperty
  a_func_busy: assert property (p_func_busy) else $error("mode changed while idle");
  property p_ac_busy;
    $changed(addressCounter) |-> busyIndicator;
  endproperty
  a_ac_busy: assert property (p_ac_busy) else $error("counter moved while idle");
  property p_offset_busy;
    $changed(displayOffset) |-> busyIndicator;
  endproperty
  a_offset_busy: assert property (p_offset_busy) else $error("shift while idle");
  property p_full_busy;
    !queueReady |-> busyIndicator;
  endproperty
  a_full_busy: assert property (p_full_busy) else $error("full queue not busy");
endmodule // clu_checker

bind clu_char_lcd clu_checker #(.HOME_CYCLES(HOME_CYCLES), .DATA_CYCLES(DATA_CYCLES),
  .BLINK_CYCLES(BLINK_CYCLES)) u_checker (.*);

/* verif/clu_host.sv */
// host processor model driving the instruction bus pins
`timescale 1ns/1ns
module clu_host (
  input wire logic clock,
  output logic regSelect,
  output logic readNotWrite,
  output logic strobe,
  output logic [7:0] hostData,
  input wire logic [7:0] busIn
);
  initial begin
    regSelect = 1'b0;
    readNotWrite = 1'b0;
    strobe = 1'b0;
    hostData = 8'h00;
  end
  // one strobe cycle; pins change after an edge and hold across the strobe
  task automatic xfer(input logic rs, input logic rw, input logic [7:0] d,
      output logic [7:0] q);
    @(posedge clock);
    regSelect <= rs;
    readNotWrite <= rw;
    hostData <= d;
    @(posedge clock);
    strobe <= 1'b1;
    repeat (6) @(posedge clock);
    q = busIn;
    strobe <= 1'b0;
    repeat (6) @(posedge clock);
    // released lines must not keep showing the last byte
    hostData <= ~d;
  endtask
  task automatic put(input logic rs, input logic [7:0] d, input logic four);
    logic [7:0] q;
    if (four) begin
      xfer(rs, 1'b0, {d[7:4], 4'h0}, q);
      xfer(rs, 1'b0, {d[3:0], 4'h0}, q);
    end else begin
      xfer(rs, 1'b0, d, q);
    end
  endtask
endmodule // clu_host

/* verif/test_char_lcd_instruction_unit.sv */
// self-checking bench of the character display instruction unit
`timescale 1ns/1ns
module test_char_lcd_instruction_unit;
  logic clock = 1'b0;
  logic srst = 1'b1;
  logic regSelect, readNotWrite, strobe, dataOe, displayEnable, cursorShow, blinkEnable;
  logic twoLineMode, tallFont, busWidth8, busyIndicator, queueReady;
  logic [7:0] hostData, dataIn, dataOut, scanChar, q;
  logic [6:0] scanAddr = 7'h00;
  logic [6:0] displayOffset, addressCounter;
  logic four = 1'b0;
  int n_errors = 0;
  int checked = 0;
  int busyLen;
  assign dataIn = dataOe ? dataOut : hostData;
  clu_char_lcd #(.HOME_CYCLES(200), .DATA_CYCLES(50), .BLINK_CYCLES(20)) uut (.*);
  clu_host host (.clock(clock), .regSelect(regSelect), .readNotWrite(readNotWrite),
    .strobe(strobe), .hostData(hostData), .busIn(dataIn));
  initial forever #5 clock = ~clock;
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wrap_up();
    $display("errors=%0d checks=%0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic idle();
    int i;
    repeat (8) @(posedge clock);
    for (i = 0; i < 20000 && busyIndicator !== 1'b0; i++) @(posedge clock);
    busyLen = i;
    if (i == 20000) begin
      n_errors++;
      wrap_up();
    end
    repeat (185) @(posedge clock);
  endtask
  task automatic span(input int lo, input int hi);
    check(8'(busyLen >= lo && busyLen <= hi), 8'h01);
  endtask
  task automatic cmd(input logic [7:0] d);
    host.put(1'b0, d, four);
    idle();
  endtask
  task automatic wdat(input logic [7:0] d);
    host.put(1'b1, d, four);
    idle();
  endtask
  task automatic rdat();
    host.xfer(1'b1, 1'b1, 8'h00, q);
    idle();
  endtask
  // -----------------------------------------------------------------
  // scenarios
  // -----------------------------------------------------------------
  task automatic t_bus4();
    cmd(8'h01);
    span(150, 210);
    check(addressCounter, 8'h00);
    cmd(8'h20);
    check(busWidth8, 8'h00);
    four = 1'b1;
    cmd(8'h2c);
    check({twoLineMode, tallFont, busWidth8}, 8'h06);
    cmd(8'h38);
    four = 1'b0;
    span(3850, 3910);
    check({twoLineMode, tallFont, busWidth8}, 8'h05);
  endtask
  task automatic t_text();
    cmd(8'ha7);
    wdat(8'h41);
    span(20, 60);
    check(addressCounter, 8'h40);
    host.xfer(1'b0, 1'b1, 8'h00, q);
    check(q, 8'h40);
    cmd(8'ha7);
    rdat();
    check(q, 8'h41);
    check(addressCounter, 8'h40);
    cmd(8'h04);
    wdat(8'h42);
    check(addressCounter, 8'h27);
    cmd(8'h07);
    wdat(8'h43);
    check(displayOffset, 8'h01);
    rdat();
    check(q, 8'h42);
    check(displayOffset, 8'h01);
    cmd(8'h03);
    check({addressCounter, 1'b0} | displayOffset, 8'h00);
    cmd(8'ha7);
    rdat();
    check(q, 8'h43);
  endtask
  task automatic t_shift();
    logic [7:0] op[4] = '{8'h10, 8'h14, 8'h18, 8'h1c};
    logic [7:0] ea[4] = '{8'h27, 8'h40, 8'h40, 8'h40};
    logic [7:0] eo[4] = '{8'h00, 8'h00, 8'h01, 8'h00};
    for (int k = 0; k < 4; k++) begin
      cmd(op[k]);
      check(addressCounter, ea[k]);
      check(displayOffset, eo[k]);
    end
    cmd(8'h05);
    wdat(8'h44);
    check(displayOffset, 8'h27);
    check(addressCounter, 8'h27);
  endtask
  task automatic t_onoff();
    logic on = 1'b0;
    logic off = 1'b0;
    cmd(8'h80);
    cmd(8'h0f);
    check({displayEnable, cursorShow, blinkEnable}, 8'h07);
    repeat (100) begin
      @(posedge clock);
      on = on | (scanChar === 8'hff);
      off = off | (scanChar === 8'h20);
    end
    check({on, off}, 8'h03);
    cmd(8'h0d);
    check({displayEnable, cursorShow, blinkEnable}, 8'h05);
    cmd(8'h08);
    scanAddr <= 7'h40;
    repeat (3) @(posedge clock);
    check(scanChar, 8'h20);
    check(blinkEnable, 8'h00);
  endtask
  task automatic t_glyph();
    cmd(8'h7f);
    check(addressCounter, 8'h3f);
    wdat(8'h1b);
    check(addressCounter, 8'h3e);
    check(displayOffset, 8'h27);
    cmd(8'h7f);
    rdat();
    check(q, 8'h1b);
    cmd(8'h90);
    check(addressCounter, 8'h10);
  endtask
  // a slow clear ahead of a burst of writes fills the command queue
  task automatic t_queue();
    logic full = 1'b0;
    host.put(1'b0, 8'h01, 1'b0);
    for (int k = 0; k < 24; k++) begin
      host.put(1'b1, 8'h30 + 8'(k), 1'b0);
      full = full | (queueReady === 1'b0);
    end
    check(full, 8'h01);
    idle();
    cmd(8'h81);
    rdat();
    check(q, 8'h31);
    cmd(8'ha7);
    rdat();
    check(q, 8'h20);
  endtask
  initial begin
    repeat (10) @(posedge clock);
    srst <= 1'b0;
    repeat (3) @(posedge clock);
    check({busyIndicator, queueReady, busWidth8}, 8'h03);
    t_bus4();
    t_text();
    t_shift();
    t_onoff();
    t_glyph();
    t_queue();
    wrap_up();
  end
endmodule // test_char_lcd_instruction_unit
